// ---- core/vic_consts.svh ----
/*
 * Register offsets, source indices, reset values and counts of the vectored interrupt controller.
 * Assumes inclusion by its bare name from the package and the design file.
 */
// What this block does
// - Thirty-two request channels, each with its own fixed priority position.
// - Drives fast and vectored requests; the fast request outranks the vectored one.
// - Two identical sixteen-channel units cascade into one prioritised controller.
// - The fast request carries no vector; firmware need not read the controller.
// - Firmware routes each channel separately to the fast request instead of vectored.
// - The vectored request is the OR of active vectored channels not held by the channel in service.
// - Channel 0 has highest priority, channel 31 lowest, fixed by index.
// - Firmware maps any source onto any channel, which sets its priority.
// - On a vectored request the winner resolves; firmware reads the winning channel number and vector.
// - Firmware forces a request on any channel, treated like a hardware request.
// - Five inputs come from the wake-up unit, twenty-seven from on-chip sources.
// - Wake-up channel is the OR of thirty pins, clock and resume inputs.
// - Four wake-up group channels each OR eight sources; group 0 mixes pins.
// - Each timer request ORs two capture, two compare and overflow events.
// - Each serial port request ORs its five interrupt conditions.
// - DMA request ORs eight channel interrupts; motor request ORs eight interrupts.
// - Bus resume goes straight to channel 30 and also into the wake-up unit.
// - Channel 31 carries prefetch queue and branch cache special interrupts.
// - The vector read is a single access served from one dedicated entry.
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH
`define VIC_CH_N 32
`define VIC_UNIT_CH 16
`define VIC_SRC_N 32
`define VIC_OFS_ENABLE 8'h00
`define VIC_OFS_FAST_SEL 8'h04
`define VIC_OFS_FORCE 8'h08
`define VIC_OFS_RAW 8'h0c
`define VIC_OFS_FAST_STAT 8'h10
`define VIC_OFS_IRQ_STAT 8'h14
`define VIC_OFS_VECT 8'h18
`define VIC_OFS_SRC_ID 8'h1c
`define VIC_OFS_DONE 8'h20
`define VIC_OFS_DEF_VECT 8'h24
`define VIC_OFS_MAP_BASE 8'h40
`define VIC_OFS_VADDR_BASE 8'hc0
`define VIC_RST_WORD 32'h0000_0000
`define VIC_NO_WINNER 6'h20
`define VIC_SRC_WAKE_ALL 5'h19
`define VIC_SRC_WAKE_G0 5'h1a
`define VIC_SRC_RESUME 5'h1e
`define VIC_SRC_PREFETCH 5'h1f
`endif

// ---- core/vic_pkg.sv ----
/*
 * Types of the vectored interrupt controller.
 * Assumes the constants header sits beside it.
 */
`include "vic_consts.svh"
package vic_pkg;
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } vic_avm_req_t;

    typedef struct packed {
        logic [3:0] timer_capture_event;
        logic [3:0] timer_capture_event_b;
        logic [3:0] timer_compare_event;
        logic [3:0] timer_compare_event_b;
        logic [3:0] timer_overflow;
        logic [2:0][4:0] uart_cond;
        logic [7:0] dma_ch;
        logic [7:0] motor_control_unit;
        logic [29:0] wake_pin;
        logic rtc_wake;
        logic bus_resume;
    } vic_grouped_src_t;

    typedef enum logic [2:0] {
        VIC_IDLE = 3'b001,
        VIC_ANSWER = 3'b010,
        VIC_HOLD = 3'b100
    } vic_bus_state_t;
endpackage : vic_pkg

// ---- core/vectored_irq_ctrl.sv ----
/*
 * Thirty-two channel vectored interrupt controller built from two cascaded sixteen-channel units,
 * with an Avalon-MM slave for its registers.
 * Assumes request inputs synchronous to core_clk and a master that holds each request until
 * waitrequest is seen low.
 */
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
module vic_unit #(
    parameter int CH = 16
) (
    input wire logic [CH-1:0] req,
    input wire logic [CH-1:0] hold_mask,
    input wire logic chain_in,
    output logic any,
    output logic [$clog2(CH):0] win
);
    // Lowest index wins; a request in the upper unit only counts when chain_in is low.
    function automatic logic [$clog2(CH):0] first_set(input logic [CH-1:0] v);
        first_set = CH[$clog2(CH):0];
        for (int i = CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = i[$clog2(CH):0];
            end
        end
    endfunction : first_set

    logic [CH-1:0] live;
    assign live = req & ~hold_mask;
    assign any = |live | chain_in;
    assign win = chain_in ? CH[$clog2(CH):0] : first_set(live);
endmodule : vic_unit

module vectored_irq_ctrl
    import vic_pkg::*;
#(
    parameter int CH_N = `VIC_CH_N
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic watchdog_timer_mode,
    input wire logic debug_rx_cmd,
    input wire logic debug_tx_cmd,
    input wire logic [1:0] usb_irq,
    input wire logic clock_control_unit,
    input wire logic ethernet_irq,
    input wire logic can_irq,
    input wire logic adc_irq,
    input wire logic [1:0] i2c_irq,
    input wire logic [1:0] sync_serial_port,
    input wire logic low_voltage_warning,
    input wire logic rtc_irq,
    input wire logic prefetch_branch_cache_unit,
    input wire vic_grouped_src_t grouped_src,
    output logic fast_interrupt_request,
    output logic irq_request
);
    // The channel map, masks and cascade are sized for exactly two sixteen-channel units.
    generate
        if (CH_N != 32) begin : g_bad_ch
            $error("Only 32 channels are supported.");
        end
    endgenerate

    localparam int UCH = `VIC_UNIT_CH;
    logic [31:0] src;
    logic [31:0] enable;
    logic [31:0] fast_sel;
    logic [31:0] force_req;
    logic [31:0][4:0] chan_map;
    logic [31:0][31:0] vaddr;
    logic [31:0] def_vect;
    logic [31:0] chan_raw;
    logic [31:0] chan_act;
    logic [31:0] hold_mask;
    logic [5:0] active_ch;
    logic [5:0] winner;
    logic any_lo;
    logic any_hi;
    logic [4:0] win_lo;
    logic [4:0] win_hi;
    logic [31:0] vect_out;
    logic [5:0] winner_id;
    vic_bus_state_t bus_state;

    logic [3:0] timer_req;
    logic [2:0] uart_req;
    logic [3:0] wake_grp;
    logic wake_all;
    logic [31:0] wake_in;
    assign wake_in = {grouped_src.bus_resume, grouped_src.rtc_wake, grouped_src.wake_pin};
    assign wake_all = |wake_in;

    // Group 0 holds six port-3 pins plus clock and resume; the rest are whole ports.
    assign wake_grp[0] = |{grouped_src.rtc_wake, grouped_src.bus_resume,
                           grouped_src.wake_pin[5:0]};
    genvar g;
    generate
        for (g = 1; g < 4; g++) begin : g_wgrp
            assign wake_grp[g] = |grouped_src.wake_pin[g*8-2 +: 8];
        end
        for (g = 0; g < 4; g++) begin : g_tim
            assign timer_req[g] = grouped_src.timer_capture_event[g]
                | grouped_src.timer_capture_event_b[g] | grouped_src.timer_compare_event[g]
                | grouped_src.timer_compare_event_b[g] | grouped_src.timer_overflow[g];
        end
        for (g = 0; g < 3; g++) begin : g_uart
            assign uart_req[g] = |grouped_src.uart_cond[g];
        end
    endgenerate

    // Source numbering follows the recommended channel order; 5 wake-up, 27 on-chip.
    assign src = {prefetch_branch_cache_unit, grouped_src.bus_resume, wake_grp, wake_all,
                  rtc_irq, low_voltage_warning, sync_serial_port, i2c_irq, uart_req, adc_irq,
                  |grouped_src.motor_control_unit, can_irq, |grouped_src.dma_ch, ethernet_irq,
                  clock_control_unit, usb_irq, timer_req, debug_tx_cmd, debug_rx_cmd, 1'b0,
                  watchdog_timer_mode};

    // Channel 1 is the firmware interrupt, carried by the force register.
    generate
        for (g = 0; g < 32; g++) begin : g_chan
            assign chan_raw[g] = src[chan_map[g]] | force_req[g];
            assign chan_act[g] = chan_raw[g] & enable[g];
        end
    endgenerate

    assign fast_interrupt_request = |(chan_act & fast_sel);

    // Service holds mask the active channel and everything below it.
    always_comb begin
        hold_mask = '0;
        for (int i = 0; i < 32; i++) begin
            if (active_ch != `VIC_NO_WINNER && i >= int'(active_ch)) begin
                hold_mask[i] = 1'b1;
            end
        end
    end

    vic_unit #(.CH(UCH)) u_hi (
        .req(chan_act[31:16] & ~fast_sel[31:16]),
        .hold_mask(hold_mask[31:16]),
        .chain_in(any_lo),
        .any(any_hi),
        .win(win_hi)
    );
    vic_unit #(.CH(UCH)) u_lo (
        .req(chan_act[15:0] & ~fast_sel[15:0]),
        .hold_mask(hold_mask[15:0]),
        .chain_in(1'b0),
        .any(any_lo),
        .win(win_lo)
    );

    assign winner = any_lo ? {1'b0, win_lo} : (any_hi ? {1'b0, win_hi} + 6'h10 : `VIC_NO_WINNER);
    assign irq_request = any_lo | any_hi;

    assign vect_out = (winner == `VIC_NO_WINNER) ? def_vect : vaddr[winner[4:0]];
    assign winner_id = winner;

    // A vector read latches the winner as the channel in service; a done write clears it.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            active_ch <= `VIC_NO_WINNER;
        end else if (bus_state == VIC_ANSWER && avs_read && avs_address == `VIC_OFS_VECT
                     && winner != `VIC_NO_WINNER) begin
            active_ch <= winner;
        end else if (bus_state == VIC_ANSWER && avs_write && avs_address == `VIC_OFS_DONE) begin
            active_ch <= `VIC_NO_WINNER;
        end
    end

    // Each access costs one wait cycle, two if it starts in VIC_HOLD; the answer follows in the next cycle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_state <= VIC_IDLE;
        end else begin
            unique case (bus_state)
                VIC_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state <= VIC_ANSWER;
                    end
                end
                VIC_ANSWER: bus_state <= VIC_HOLD;
                VIC_HOLD: bus_state <= VIC_IDLE;
                default: bus_state <= VIC_IDLE;
            endcase
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && bus_state != VIC_ANSWER;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                old[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        merge = old;
    endfunction : merge

    logic wr_take;
    assign wr_take = bus_state == VIC_ANSWER && avs_write;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enable <= `VIC_RST_WORD;
            fast_sel <= `VIC_RST_WORD;
            force_req <= `VIC_RST_WORD;
            def_vect <= `VIC_RST_WORD;
            chan_map <= '0;
            vaddr <= '0;
        end else if (wr_take) begin
            if (avs_address == `VIC_OFS_ENABLE) begin
                enable <= merge(enable, avs_writedata, avs_byteenable);
            end
            if (avs_address == `VIC_OFS_FAST_SEL) begin
                fast_sel <= merge(fast_sel, avs_writedata, avs_byteenable);
            end
            if (avs_address == `VIC_OFS_FORCE) begin
                force_req <= merge(force_req, avs_writedata, avs_byteenable);
            end
            if (avs_address == `VIC_OFS_DEF_VECT) begin
                def_vect <= merge(def_vect, avs_writedata, avs_byteenable);
            end
            for (int i = 0; i < 32; i++) begin
                if (avs_address == `VIC_OFS_MAP_BASE + 8'(i * 4) && avs_byteenable[0]) begin
                    chan_map[i] <= avs_writedata[4:0];
                end
                if (avs_address == `VIC_OFS_VADDR_BASE + 8'(i * 4)) begin
                    vaddr[i] <= merge(vaddr[i], avs_writedata, avs_byteenable);
                end
            end
        end
    end

    // The vector word is a single one-access read once the winner resolves.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (bus_state == VIC_IDLE && avs_read) begin
            avs_readdata <= '0;
            unique case (avs_address)
                `VIC_OFS_ENABLE: avs_readdata <= enable;
                `VIC_OFS_FAST_SEL: avs_readdata <= fast_sel;
                `VIC_OFS_FORCE: avs_readdata <= force_req;
                `VIC_OFS_RAW: avs_readdata <= chan_raw;
                `VIC_OFS_FAST_STAT: avs_readdata <= chan_act & fast_sel;
                `VIC_OFS_IRQ_STAT: avs_readdata <= chan_act & ~fast_sel;
                `VIC_OFS_VECT: avs_readdata <= vect_out;
                `VIC_OFS_SRC_ID: avs_readdata <= {26'h0, winner_id};
                `VIC_OFS_DEF_VECT: avs_readdata <= def_vect;
                default: begin
                    for (int i = 0; i < 32; i++) begin
                        if (avs_address == `VIC_OFS_MAP_BASE + 8'(i * 4)) begin
                            avs_readdata <= {27'h0, chan_map[i]};
                        end
                        if (avs_address == `VIC_OFS_VADDR_BASE + 8'(i * 4)) begin
                            avs_readdata <= vaddr[i];
                        end
                    end
                end
            endcase
        end
    end

    a_fast_route: assert property (@(posedge core_clk) disable iff (sys_rst)
        (|(chan_act & fast_sel)) |-> fast_interrupt_request)
        else $error("Fast routed channel did not raise the fast request.");
    a_irq_or: assert property (@(posedge core_clk) disable iff (sys_rst)
        ((|(chan_act & ~fast_sel & ~hold_mask)) == irq_request))
        else $error("Vectored request differs from OR of live channels.");
    a_prio_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        (chan_act[0] && !fast_sel[0] && !hold_mask[0]) |-> winner == 6'h0)
        else $error("Channel 0 did not win.");
    a_force_chan: assert property (@(posedge core_clk) disable iff (sys_rst)
        force_req[3] |-> chan_raw[3])
        else $error("Forced channel not raised.");
    a_wake_all: assert property (@(posedge core_clk) disable iff (sys_rst)
        grouped_src.rtc_wake |-> wake_all && wake_grp[0])
        else $error("Wake-up OR missed clock input.");
    a_hold_lower: assert property (@(posedge core_clk) disable iff (sys_rst)
        (active_ch != `VIC_NO_WINNER && winner != `VIC_NO_WINNER) |-> winner < active_ch)
        else $error("Lower channel preempted service.");
    a_bus_answer: assert property (@(posedge core_clk) disable iff (sys_rst)
        (avs_read && bus_state == VIC_IDLE) |=> !avs_waitrequest)
        else $error("Read not answered in one cycle.");
    a_done_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr_take && avs_address == `VIC_OFS_DONE) |=> active_ch == `VIC_NO_WINNER)
        else $error("Completion did not end service.");
endmodule : vectored_irq_ctrl
`default_nettype wire

// ---- test/vic_src_model.sv ----
/*
 * Model of the on-chip sources that raise requests towards the controller.
 * Assumes the bench names the wanted source indices on want, in recommended order.
 */
`timescale 1ns/1ps
`default_nettype none
module vic_src_model
    import vic_pkg::*;
(
    input wire logic core_clk,
    input wire logic [31:0] want,
    output logic [31:0] flat,
    output vic_grouped_src_t grouped_src
);
    vic_grouped_src_t g;
    int k;
    initial begin
        flat = 32'h0;
        grouped_src = '0;
    end
    // Each grouped request but the all-wake one is raised through one member picked at random; all-wake uses rtc_wake.
    always @(posedge core_clk) begin
        g = '0;
        for (int t = 0; t < 4; t++) begin
            k = want[4+t] ? int'($urandom_range(4)) : 7;
            g.timer_capture_event[t] = (k == 0);
            g.timer_capture_event_b[t] = (k == 1);
            g.timer_compare_event[t] = (k == 2);
            g.timer_compare_event_b[t] = (k == 3);
            g.timer_overflow[t] = (k == 4);
        end
        for (int u = 0; u < 3; u++) begin
            if (want[16+u]) g.uart_cond[u][$urandom_range(4)] = 1'b1;
        end
        if (want[12]) g.dma_ch[$urandom_range(7)] = 1'b1;
        if (want[14]) g.motor_control_unit[$urandom_range(7)] = 1'b1;
        if (want[26]) g.wake_pin[$urandom_range(5)] = 1'b1;
        for (int p = 1; p < 4; p++) begin
            if (want[26+p]) g.wake_pin[8*p-2+$urandom_range(7)] = 1'b1;
        end
        g.rtc_wake = want[25];
        g.bus_resume = want[30];
        grouped_src <= g;
        flat <= want & 32'hffff_fffd;
    end
endmodule : vic_src_model
`default_nettype wire

// ---- test/tb_top.sv ----
/*
 * Self-checking bench of the vectored interrupt controller.
 * Assumes the source model beside it and the register map of the constants header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
module tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] want = 32'h0;
    logic [31:0] flat;
    vic_pkg::vic_grouped_src_t grouped_src;
    logic fast_interrupt_request;
    logic irq_request;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    logic [31:0] tw [6] = '{32'hffff_ffff, 32'h8000_0000, 32'h0, 32'h4000_0000, 32'h1,
                            32'hffff_ffff};
    logic [31:0] ten [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
                             32'hffff_ffff, 32'h0};
    logic [31:0] tfs [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    logic [31:0] tfc [6] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};

    vectored_irq_ctrl vectored_irq_ctrl_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .watchdog_timer_mode(flat[0]),
        .debug_rx_cmd(flat[2]), .debug_tx_cmd(flat[3]), .usb_irq(flat[9:8]),
        .clock_control_unit(flat[10]), .ethernet_irq(flat[11]), .can_irq(flat[13]),
        .adc_irq(flat[15]), .i2c_irq(flat[20:19]), .sync_serial_port(flat[22:21]),
        .low_voltage_warning(flat[23]), .rtc_irq(flat[24]),
        .prefetch_branch_cache_unit(flat[31]), .grouped_src(grouped_src),
        .fast_interrupt_request(fast_interrupt_request), .irq_request(irq_request)
    );
    vic_src_model vic_src_model_inst (
        .core_clk(core_clk), .want(want), .flat(flat), .grouped_src(grouped_src)
    );

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            $display("FAIL %0t timeout", $time);
            complete_run();
        end
    end

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    // Wake-up inputs overlap: any pin feeds the all-wake channel, clock and resume feed group 0.
    function automatic logic [31:0] eff(input logic [31:0] w);
        logic [31:0] e;
        e = w & 32'hffff_fffd;
        e[26] = w[26] | w[25] | w[30];
        e[25] = |w[30:25];
        return e;
    endfunction : eff

    function automatic logic [31:0] lowest(input logic [31:0] v);
        for (int c = 0; c < 32; c++) if (v[c]) return 32'(c);
        return 32'h20;
    endfunction : lowest

    function automatic logic [31:0] vaddr(input logic [31:0] c);
        return 32'h0000_8000 + (c << 4);
    endfunction : vaddr

    initial begin
        logic [31:0] q, w, en, fs, fc, act, vec, win;
        void'($urandom(32'h25213e73));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk_bit(irq_request, 1'b0, "irq after reset");
        chk_bit(fast_interrupt_request, 1'b0, "fast after reset");
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, (i < 3) ? 8'(4 * i) : 8'h30, 32'h0, q);
            chk_word(q, 32'h0, "reset or unmapped read");
        end
        $display("test reset done");
        for (int i = 0; i < 32; i++) wr(`VIC_OFS_MAP_BASE + 8'(4 * i), 32'(i));
        for (int i = 0; i < 16; i++) wr(`VIC_OFS_VADDR_BASE + 8'(4 * i), vaddr(32'(i)));
        wr(`VIC_OFS_DEF_VECT, 32'h0000_0f00);
        for (int i = 0; i < 46; i++) begin
            if (i < 6) begin
                w = tw[i];
                en = ten[i];
                fs = tfs[i];
                fc = tfc[i];
            end else begin
                w = $urandom & $urandom;
                en = $urandom | $urandom;
                fs = $urandom & $urandom & $urandom;
                fc = $urandom & $urandom & $urandom;
            end
            wr(`VIC_OFS_ENABLE, en);
            wr(`VIC_OFS_FAST_SEL, fs);
            wr(`VIC_OFS_FORCE, fc);
            @(posedge core_clk);
            want <= w;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            act = (eff(w) | fc) & en;
            vec = act & ~fs;
            win = lowest(vec);
            chk_bit(irq_request, |vec, "vectored request");
            chk_bit(fast_interrupt_request, |(act & fs), "fast request");
            bus(1'b0, `VIC_OFS_RAW, 32'h0, q);
            chk_word(q, eff(w) | fc, "raw channels");
            bus(1'b0, `VIC_OFS_FAST_STAT, 32'h0, q);
            chk_word(q, act & fs, "fast status");
            bus(1'b0, `VIC_OFS_IRQ_STAT, 32'h0, q);
            chk_word(q, vec, "vectored status");
            bus(1'b0, `VIC_OFS_SRC_ID, 32'h0, q);
            chk_word(q, win, "winner");
            if (win < 32'h10 || win == 32'h20) begin
                bus(1'b0, `VIC_OFS_VECT, 32'h0, q);
                chk_word(q, (win == 32'h20) ? 32'h0000_0f00 : vaddr(win), "vector");
            end
            wr(`VIC_OFS_DONE, 32'h0);
            $display("test %0d done", i);
        end
        wr(`VIC_OFS_ENABLE, 32'hffff_ffff);
        wr(`VIC_OFS_FAST_SEL, 32'h0);
        wr(`VIC_OFS_FORCE, 32'h0);
        wr(`VIC_OFS_MAP_BASE + 8'h14, 32'h14);
        @(posedge core_clk);
        want <= 32'h0010_0000;
        repeat (3) @(posedge core_clk);
        bus(1'b0, `VIC_OFS_VECT, 32'h0, q);
        chk_word(q, vaddr(32'h5), "remapped vector");
        @(negedge core_clk);
        chk_bit(irq_request, 1'b0, "lower channels held in service");
        wr(`VIC_OFS_FORCE, 32'h1);
        bus(1'b0, `VIC_OFS_SRC_ID, 32'h0, q);
        chk_word(q, 32'h0, "higher channel preempts");
        wr(`VIC_OFS_DONE, 32'h0);
        wr(`VIC_OFS_FORCE, 32'h0);
        @(negedge core_clk);
        chk_bit(irq_request, 1'b1, "service released");
        bus(1'b0, `VIC_OFS_SRC_ID, 32'h0, q);
        chk_word(q, 32'h5, "remapped winner");
        $display("test remap done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
